// ---- alu_status.sv ----
// processor status register: ALU flags, reset status and bank select
// Functional notes
// RQ1 - the status register can be the destination of any instruction like an ordinary file register.
// RQ2 - an instruction that itself affects zero, nibble carry or carry discards its written value for those bits.
// RQ3 - the expiry and power-down flags never change through an instruction write, only through hardware events.
// RQ4 - a clear-file of the status register zeros the top three bits, keeps the rest and sets the zero flag.
// RQ5 - software should alter the register only with bit clear, bit set, nibble swap and move-from-W.
// RQ6 - software should keep the indirect bank bit and the upper bank bit at zero.
// RQ7 - in subtraction carry and nibble carry are set when no borrow occurs.
// RQ8 - the register decodes at 03h and 83h, both reaching the same flops whatever bank is selected.
// RQ9 - bank select low picks bank 0 (00h-7Fh) or bank 1 (80h-FFh) for direct addressing.
// RQ10 - power-up, watchdog clear set both reset flags; sleep sets expiry, clears power-down; timeout clears expiry.
//
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
module alu_status (
   input wire logic clk_i,                         // 50 MHz core clock
   input wire logic rst_n_i,                       // power-up reset, async, active low
   input wire status_pkg::instr_t instr_i,         // executed instruction
   input wire logic wdt_clear_i,                   // watchdog clear instruction pulse
   input wire logic sleep_i,                       // sleep instruction pulse
   input wire logic wdt_timeout_i,                 // watchdog time-out pulse
   output logic [7:0] status_o,                    // register contents
   output logic [7:0] result_o,                    // ALU result of instr_i
   output logic [7:0] data_addr_o,                 // banked direct data address
   output logic status_hit_o,                      // instr_i targets this register
   input wire logic [status_pkg::AXI_ADDR_W-1:0] s_axi_awaddr, // write address
   input wire logic s_axi_awvalid,                 // write address valid
   output logic s_axi_awready,                     // write address ready
   input wire logic [31:0] s_axi_wdata,            // write data
   input wire logic [3:0] s_axi_wstrb,             // write strobes
   input wire logic s_axi_wvalid,                  // write data valid
   output logic s_axi_wready,                      // write data ready
   output logic [1:0] s_axi_bresp,                 // write response
   output logic s_axi_bvalid,                      // write response valid
   input wire logic s_axi_bready,                  // write response ready
   input wire logic [status_pkg::AXI_ADDR_W-1:0] s_axi_araddr, // read address
   input wire logic s_axi_arvalid,                 // read address valid
   output logic s_axi_arready,                     // read address ready
   output logic [31:0] s_axi_rdata,                // read data
   output logic [1:0] s_axi_rresp,                 // read response
   output logic s_axi_rvalid,                      // read data valid
   input wire logic s_axi_rready                   // read data ready
);
   import status_pkg::*;

   function automatic logic addr_hit(input logic [AXI_ADDR_W-1:0] a);
      addr_hit = (a == STATUS_ADDR) || (a == STATUS_ALT_ADDR);
   endfunction : addr_hit

   logic [7:0] status, next_status;
   flags_t alu_flags;
   logic [7:0] alu_result;
   logic core_wr;

   flag_calc u_calc (
      .instr_i(instr_i),
      .result_o(alu_result),
      .flags_o(alu_flags)
   );

   // RQ8 bank ignored in decode
   assign status_hit_o = instr_i.valid && instr_i.to_file && (instr_i.file == FILE_STATUS);
   assign core_wr = status_hit_o;
   // RQ9 direct bank select
   assign data_addr_o = {status[BIT_RP0], instr_i.file};
   assign result_o = alu_result;
   assign status_o = status;

   // bus write channel state
   logic aw_got, next_aw_got, w_got, next_w_got, bvalid, next_bvalid;
   logic [AXI_ADDR_W-1:0] aw_addr, next_aw_addr;
   logic [7:0] w_byte, next_w_byte;
   logic w_en, next_w_en;
   logic [1:0] bresp, next_bresp;
   logic bus_commit;

   assign s_axi_awready = !aw_got && !bvalid;
   assign s_axi_wready = !w_got && !bvalid;
   assign s_axi_bvalid = bvalid;
   assign s_axi_bresp = bresp;
   // bus write waits while the core writes the register, so no instruction update is lost
   assign bus_commit = aw_got && w_got && !bvalid && !core_wr;

   always_comb begin
      next_aw_got = aw_got;
      next_w_got = w_got;
      next_aw_addr = aw_addr;
      next_w_byte = w_byte;
      next_w_en = w_en;
      next_bvalid = bvalid;
      next_bresp = bresp;
      if (s_axi_awvalid && s_axi_awready) begin
         next_aw_got = 1'b1;
         next_aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_w_got = 1'b1;
         next_w_byte = s_axi_wdata[7:0];
         next_w_en = s_axi_wstrb[0];
      end
      if (bus_commit) begin
         next_aw_got = 1'b0;
         next_w_got = 1'b0;
         next_bvalid = 1'b1;
         next_bresp = addr_hit(aw_addr) ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid && s_axi_bready) begin
         next_bvalid = 1'b0;
      end
   end

   // register update
   always_comb begin
      next_status = status;
      if (core_wr) begin
         // RQ1 ordinary destination write
         next_status[BIT_IRP:BIT_RP0] = alu_result[BIT_IRP:BIT_RP0];
         // RQ2 affected flags not written
         if (alu_flags.en == 3'h0) begin
            next_status[BIT_Z:BIT_C] = alu_result[BIT_Z:BIT_C];
         end
      end else if (bus_commit && addr_hit(aw_addr) && w_en) begin
         next_status[BIT_IRP:BIT_RP0] = w_byte[BIT_IRP:BIT_RP0];
         next_status[BIT_Z:BIT_C] = w_byte[BIT_Z:BIT_C];
      end
      // RQ4 clear lands as flags from the ALU
      if (instr_i.valid) begin
         for (int i = 0; i < 3; i++) begin
            if (alu_flags.en[i]) begin
               next_status[i] = alu_flags.val[i];
            end
         end
      end
      // RQ3 reset flags from events only
      // RQ10 watchdog clear, sleep and time-out
      if (wdt_clear_i) begin
         next_status[BIT_TO] = 1'b1;
         next_status[BIT_PD] = 1'b1;
      end else if (sleep_i) begin
         next_status[BIT_TO] = 1'b1;
         next_status[BIT_PD] = 1'b0;
      end
      // time-out wins over a simultaneous clear or sleep
      if (wdt_timeout_i) begin
         next_status[BIT_TO] = 1'b0;
      end
   end

   // read channel
   logic rvalid, next_rvalid;
   logic [31:0] rdata, next_rdata;
   logic [1:0] rresp, next_rresp;

   assign s_axi_arready = !rvalid;
   assign s_axi_rvalid = rvalid;
   assign s_axi_rdata = rdata;
   assign s_axi_rresp = rresp;

   always_comb begin
      next_rvalid = rvalid;
      next_rdata = rdata;
      next_rresp = rresp;
      if (s_axi_arvalid && s_axi_arready) begin
         next_rvalid = 1'b1;
         next_rdata = addr_hit(s_axi_araddr) ? {24'h000000, status} : 32'h00000000;
         next_rresp = addr_hit(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid && s_axi_rready) begin
         next_rvalid = 1'b0;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         // RQ10 power-up value
         status <= STATUS_RESET;
         aw_got <= 1'b0;
         w_got <= 1'b0;
         aw_addr <= '0;
         w_byte <= 8'h00;
         w_en <= 1'b0;
         bvalid <= 1'b0;
         bresp <= RESP_OKAY;
         rvalid <= 1'b0;
         rdata <= 32'h00000000;
         rresp <= RESP_OKAY;
      end else begin
         status <= next_status;
         aw_got <= next_aw_got;
         w_got <= next_w_got;
         aw_addr <= next_aw_addr;
         w_byte <= next_w_byte;
         w_en <= next_w_en;
         bvalid <= next_bvalid;
         bresp <= next_bresp;
         rvalid <= next_rvalid;
         rdata <= next_rdata;
         rresp <= next_rresp;
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   no_flag_write_a: assert property ( // RQ2
      core_wr && (alu_flags.en == 3'h7) && !wdt_timeout_i |=> status[BIT_Z:BIT_C] == $past(alu_flags.val))
      else $error("written value reached ALU-owned flags");
   reset_flags_held_a: assert property ( // RQ3
      !wdt_clear_i && !sleep_i && !wdt_timeout_i |=> $stable(status[BIT_TO:BIT_PD]))
      else $error("reset flags changed without event");
   clear_file_a: assert property ( // RQ4
      core_wr && instr_i.op == OP_CLEAR && !wdt_clear_i && !sleep_i && !wdt_timeout_i
      |=> status == {3'h0, $past(status[BIT_TO:BIT_DC]) | 4'h2, $past(status[BIT_C])})
      else $error("clear of register gave wrong value");
   sub_borrow_a: assert property ( // RQ7
      instr_i.valid && instr_i.op == OP_SUB |=> status[BIT_C] == ($past(instr_i.fval) >= $past(instr_i.wval)))
      else $error("subtract carry not active-low borrow");
   both_banks_a: assert property ( // RQ8
      instr_i.valid && instr_i.to_file && instr_i.file == FILE_STATUS && instr_i.op == OP_MOVE
      |=> status[BIT_IRP:BIT_RP0] == $past(instr_i.wval[BIT_IRP:BIT_RP0]))
      else $error("register missed in one bank");
   bank_addr_a: assert property ( // RQ9
      data_addr_o[7] == status[BIT_RP0] && data_addr_o[6:0] == instr_i.file)
      else $error("direct address bank wrong");
   sleep_flags_a: assert property ( // RQ10
      sleep_i && !wdt_clear_i && !wdt_timeout_i |=> status[BIT_TO:BIT_PD] == 2'h2)
      else $error("sleep did not set expiry and clear power-down");
   timeout_flag_a: assert property ( // RQ10
      wdt_timeout_i |=> !status[BIT_TO])
      else $error("time-out did not clear expiry flag");
   move_write_a: assert property ( // RQ1
      core_wr && instr_i.op == OP_MOVE |=> status[BIT_Z:BIT_C] == $past(instr_i.wval[BIT_Z:BIT_C]))
      else $error("move to register not stored");
   bus_answer_a: assert property (
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read not answered next cycle");

   clear_file_c: cover property (core_wr && instr_i.op == OP_CLEAR);
   bus_write_c: cover property (bus_commit && addr_hit(aw_addr));
   sub_borrow_c: cover property (instr_i.valid && instr_i.op == OP_SUB && instr_i.fval < instr_i.wval);
   sleep_then_timeout_c: cover property (sleep_i ##[1:20] wdt_timeout_i);
endmodule : alu_status
`default_nettype wire

// ---- status_pkg.sv ----
// constants and types shared by the status register block
`default_nettype none
package status_pkg;
   // register indices as printed; bus byte address is four times the index
   localparam logic [7:0] STATUS_INDEX = 8'h03;
   localparam logic [7:0] STATUS_ALT_INDEX = 8'h83;
   localparam int AXI_ADDR_W = 12;
   localparam logic [AXI_ADDR_W-1:0] STATUS_ADDR = {2'h0, STATUS_INDEX, 2'h0};
   localparam logic [AXI_ADDR_W-1:0] STATUS_ALT_ADDR = {2'h0, STATUS_ALT_INDEX, 2'h0};
   // file address of the register inside either bank
   localparam logic [6:0] FILE_STATUS = 7'h03;
   // field positions
   localparam int BIT_C = 0;
   localparam int BIT_DC = 1;
   localparam int BIT_Z = 2;
   localparam int BIT_PD = 3;
   localparam int BIT_TO = 4;
   localparam int BIT_RP0 = 5;
   localparam int BIT_RP1 = 6;
   localparam int BIT_IRP = 7;
   // power-up value: expiry and power-down flags set, all else clear
   localparam logic [7:0] STATUS_RESET = 8'h18;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [3:0] {
      OP_MOVE = 4'h0,
      OP_ADD = 4'h1,
      OP_SUB = 4'h2,
      OP_AND = 4'h3,
      OP_IOR = 4'h4,
      OP_XOR = 4'h5,
      OP_CLEAR = 4'h6,
      OP_SWAP = 4'h7,
      OP_INC = 4'h8,
      OP_BITCLR = 4'h9,
      OP_BITSET = 4'hA
   } alu_op_t;

   // one executed instruction from the core
   typedef struct packed {
      logic valid;
      alu_op_t op;
      logic to_file;
      logic [6:0] file;
      logic [7:0] fval;
      logic [7:0] wval;
      logic [2:0] bitsel;
   } instr_t;

   // flag values {z, dc, c} and which of them the instruction affects
   typedef struct packed {
      logic [2:0] val;
      logic [2:0] en;
   } flags_t;
endpackage : status_pkg
`default_nettype wire

// ---- flag_calc.sv ----
// ALU result and zero / nibble-carry / carry flag generation
`timescale 1ns/1ns
`default_nettype none
module flag_calc (
   input wire status_pkg::instr_t instr_i, // instruction being executed
   output logic [7:0] result_o,            // ALU result
   output status_pkg::flags_t flags_o      // flag values and enables
);
   import status_pkg::*;

   logic [8:0] sum;
   logic [4:0] nib;

   always_comb begin
      sum = 9'h000;
      nib = 5'h00;
      result_o = instr_i.fval;
      flags_o.val = 3'h0;
      flags_o.en = 3'h0;
      case (instr_i.op)
         OP_ADD: begin
            sum = {1'b0, instr_i.fval} + {1'b0, instr_i.wval};
            nib = {1'b0, instr_i.fval[3:0]} + {1'b0, instr_i.wval[3:0]};
            result_o = sum[7:0];
            flags_o.val = {sum[7:0] == 8'h00, nib[4], sum[8]};
            flags_o.en = 3'h7;
         end
         // RQ7 borrow flags active low
         OP_SUB: begin
            result_o = instr_i.fval - instr_i.wval;
            flags_o.val = {instr_i.fval == instr_i.wval, instr_i.fval[3:0] >= instr_i.wval[3:0],
                           instr_i.fval >= instr_i.wval};
            flags_o.en = 3'h7;
         end
         OP_AND, OP_IOR, OP_XOR, OP_INC: begin
            case (instr_i.op)
               OP_AND: result_o = instr_i.fval & instr_i.wval;
               OP_IOR: result_o = instr_i.fval | instr_i.wval;
               OP_XOR: result_o = instr_i.fval ^ instr_i.wval;
               default: result_o = instr_i.fval + 8'h01;
            endcase
            flags_o.val = {result_o == 8'h00, 2'h0};
            flags_o.en = 3'h4;
         end
         // RQ4 clear yields zero result
         OP_CLEAR: begin
            result_o = 8'h00;
            flags_o.val = 3'h4;
            flags_o.en = 3'h4;
         end
         OP_MOVE: result_o = instr_i.wval;
         OP_SWAP: result_o = {instr_i.fval[3:0], instr_i.fval[7:4]};
         OP_BITCLR: result_o = instr_i.fval & ~(8'h01 << instr_i.bitsel);
         OP_BITSET: result_o = instr_i.fval | (8'h01 << instr_i.bitsel);
         default: result_o = instr_i.fval;
      endcase
   end
endmodule : flag_calc
`default_nettype wire

// ---- core_model.sv ----
// far-side core model: turns bench commands into executed instructions
`timescale 1ns/1ns
`default_nettype none
module core_model (
   input wire status_pkg::instr_t cmd_i, // requested instruction
   input wire logic [7:0] status_i,      // live register value
   output var status_pkg::instr_t instr_o // instruction as executed
);
   import status_pkg::*;
   always_comb begin
      instr_o = cmd_i;
      // the core reads this register as the file operand
      if (cmd_i.file == FILE_STATUS) begin
         instr_o.fval = status_i;
      end
      if (cmd_i.file == FILE_STATUS && cmd_i.op == OP_MOVE) begin
         instr_o.wval[7:6] = 2'h0;
      end
   end
endmodule : core_model
`default_nettype wire

// ---- alu_status_and_bank_select_tb_top.sv ----
// self-checking bench for the status register block
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) \
   begin \
      checks_done++; \
      if ((a) !== (e)) begin \
         mismatches++; \
         $display("ERROR t=%0t got %h exp %h", $time, (a), (e)); \
      end \
   end
module alu_status_and_bank_select_tb_top;
   import status_pkg::*;
   logic clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   instr_t cmd = '0;
   instr_t instr;
   logic wdt_clear = 1'b0, sleep = 1'b0, wdt_timeout = 1'b0;
   logic [7:0] status, result, data_addr;
   logic hit, awready, wready, bvalid, arready, rvalid;
   logic [AXI_ADDR_W-1:0] awaddr = '0, araddr = '0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = '0, rdata;
   logic [1:0] bresp, rresp;
   int mismatches = 0;
   int checks_done = 0;

   core_model partner (.cmd_i(cmd), .status_i(status), .instr_o(instr));
   alu_status DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .instr_i(instr), .wdt_clear_i(wdt_clear),
      .sleep_i(sleep), .wdt_timeout_i(wdt_timeout), .status_o(status), .result_o(result),
      .data_addr_o(data_addr), .status_hit_o(hit), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

   initial begin
      forever #10 clk_i = ~clk_i;
   end

   task automatic conclude();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : conclude

   task automatic hang();
      mismatches++;
      $display("ERROR t=%0t got %h exp %h", $time, 1'b0, 1'b1);
      conclude();
   endtask : hang

   // payload held until its own ready; response ready held until answered
   task automatic axi_wr(input logic [AXI_ADDR_W-1:0] a, input logic [7:0] d, input logic [1:0] er);
      int n;
      @(posedge clk_i);
      awaddr <= a;
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge clk_i);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid) begin
            bready <= 1'b0;
            `CHK(bresp, er)
            break;
         end
      end
      if (n == 50) hang();
   endtask : axi_wr

   task automatic axi_rd(input logic [AXI_ADDR_W-1:0] a, input logic [7:0] ed, input logic [1:0] er);
      int n;
      @(posedge clk_i);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge clk_i);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) begin
            rready <= 1'b0;
            `CHK(rdata, {24'h0, ed})
            `CHK(rresp, er)
            break;
         end
      end
      if (n == 50) hang();
   endtask : axi_rd

   task automatic apply(input alu_op_t op, input logic tf, input logic [6:0] f, input logic [7:0] fv,
      input logic [7:0] wv, input logic [2:0] b);
      @(posedge clk_i);
      cmd <= '{1'b1, op, tf, f, fv, wv, b};
      #1;
   endtask : apply

   task automatic take();
      @(posedge clk_i);
      cmd.valid <= 1'b0;
      #1;
   endtask : take

   task automatic t_bus();
      `CHK(status, 8'h18)
      axi_rd(STATUS_ALT_ADDR, 8'h18, RESP_OKAY);
      axi_wr(STATUS_ADDR, 8'h00, RESP_OKAY);
      `CHK(status, 8'h18)
      axi_wr(STATUS_ALT_ADDR, 8'h27, RESP_OKAY);
      axi_rd(STATUS_ADDR, 8'h3F, RESP_OKAY);
      axi_wr(12'h010, 8'hFF, RESP_SLVERR);
      axi_rd(12'h010, 8'h00, RESP_SLVERR);
      `CHK(status, 8'h3F)
      $display("test bus done");
   endtask : t_bus

   task automatic t_bank();
      apply(OP_MOVE, 1'b0, 7'h05, 8'h00, 8'h00, 3'h0);
      `CHK(data_addr, 8'h85)
      `CHK(hit, 1'b0)
      take();
      axi_wr(STATUS_ADDR, 8'h00, RESP_OKAY);
      apply(OP_MOVE, 1'b0, 7'h7F, 8'h00, 8'h00, 3'h0);
      `CHK(data_addr, 8'h7F)
      take();
      $display("test bank done");
   endtask : t_bank

   task automatic t_sub();
      logic [7:0] fv[3] = '{8'h10, 8'h01, 8'h35};
      logic [7:0] wv[3] = '{8'h01, 8'h02, 8'h35};
      logic [7:0] rs[3] = '{8'h0F, 8'hFF, 8'h00};
      logic [2:0] fl[3] = '{3'b001, 3'b000, 3'b111};
      for (int i = 0; i < 3; i++) begin
         apply(OP_SUB, 1'b0, 7'h20, fv[i], wv[i], 3'h0);
         `CHK(result, rs[i])
         take();
         `CHK(status, {5'h03, fl[i]})
      end
      $display("test subtract done");
   endtask : t_sub

   task automatic t_clear();
      axi_wr(STATUS_ADDR, 8'hE2, RESP_OKAY);
      `CHK(status, 8'hFA)
      apply(OP_CLEAR, 1'b1, FILE_STATUS, 8'h00, 8'h00, 3'h0);
      `CHK(hit, 1'b1)
      take();
      `CHK(status, 8'h1E)
      // add onto the register itself: flags win over the written low bits
      apply(OP_ADD, 1'b1, FILE_STATUS, 8'h00, 8'hE2, 3'h0);
      `CHK(result, 8'h00)
      take();
      `CHK(status, 8'h1F)
      $display("test clear done");
   endtask : t_clear

   // the flag-neutral move, swap, bit clear and bit set write the register; clearing bit 4 leaves it unchanged
   task automatic t_move();
      alu_op_t op[5] = '{OP_MOVE, OP_SWAP, OP_BITCLR, OP_BITCLR, OP_BITSET};
      logic [7:0] wv[5] = '{8'hE5, 8'h00, 8'h00, 8'h00, 8'h00};
      logic [2:0] b[5] = '{3'h0, 3'h0, 3'h7, 3'h4, 3'h5};
      logic [7:0] ex[5] = '{8'h3D, 8'hDB, 8'h5B, 8'h5B, 8'h7B};
      for (int i = 0; i < 5; i++) begin
         apply(op[i], 1'b1, FILE_STATUS, 8'h00, wv[i], b[i]);
         take();
         `CHK(status, ex[i])
      end
      $display("test move done");
   endtask : t_move

   task automatic t_events();
      logic [2:0] ev[4] = '{3'b100, 3'b010, 3'b001, 3'b011};
      logic [7:0] ex[4] = '{8'h73, 8'h63, 8'h7B, 8'h6B};
      for (int i = 0; i < 4; i++) begin
         @(posedge clk_i);
         {sleep, wdt_timeout, wdt_clear} <= ev[i];
         @(posedge clk_i);
         {sleep, wdt_timeout, wdt_clear} <= 3'b000;
         #1;
         `CHK(status, ex[i])
      end
      $display("test events done");
   endtask : t_events

   initial begin
      repeat (5) @(posedge clk_i);
      rst_n_i <= 1'b1;
      #1;
      t_bus();
      t_bank();
      t_sub();
      t_clear();
      t_move();
      t_events();
      conclude();
   end

   // cuts a hung handshake short
   initial begin
      repeat (5000) @(posedge clk_i);
      hang();
   end
endmodule : alu_status_and_bank_select_tb_top
`default_nettype wire
